// ===== src/ppr_consts.vh
/*
  constants of the ptp parser / pin monitor / identity hash register bank.
  assumes: included by bare name from every design file of the bank.
*/
`ifndef PPR_CONSTS_VH
`define PPR_CONSTS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PPR_IDX_W 8
`define PPR_IDX_ETYPE 8'h1c
`define PPR_IDX_OFF 8'h1d
`define PPR_IDX_GPIO 8'h1e
`define PPR_IDX_HASH 8'h1f

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PPR_ETYPE_RST 16'hf788
`define PPR_HASH_EN_BIT 12
`define PPR_HASH_W 12
`define PPR_OFF_W 8
`define PPR_GPIO_W 12
`define PPR_RESP_OKAY 2'b00
`define PPR_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define PPR_POS_W 11
`define PPR_POS_NONE 11'h7ff
`define PPR_ETYPE_POS 11'h00c
`define PPR_VLAN_ETYPE_POS 11'h010
`define PPR_TPID 16'h8100
`define PPR_TYPE_IPV4 16'h0800
`define PPR_TYPE_IPV6 16'h86dd
`define PPR_PROTO_UDP 8'h11
`define PPR_V4_PROTO_OFS 11'h00b
`define PPR_V6_NH_OFS 11'h008
`define PPR_V6_UDP_END 11'h032
`define PPR_UDP_HDR 11'h008
`define PPR_L3_OFS 11'h002
`define PPR_ID_FIRST 11'h014
`define PPR_ID_LAST 11'h01d

`endif

// ===== src/ppr_frame_scan.v
/*
  frame scanner: locates the ptp message in a received byte stream,
  reports its byte offset and strobes the ten source identity octets.
  assumes: one byte per rx_valid, rx_sof on the first byte of a frame.
*/
`timescale 1ns/10ps
`include "ppr_consts.vh"

module ppr_frame_scan (
  input wire aclk,
  input wire aresetn,
  input wire [15:0] type_match,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_sof,
  output reg [`PPR_OFF_W-1:0] offset_ff,
  output wire id_stb,
  output wire id_first,
  output wire id_last
);

  reg [`PPR_POS_W-1:0] cnt_ff;
  reg [`PPR_POS_W-1:0] et_pos_ff;
  reg [`PPR_POS_W-1:0] msg_pos_ff;
  reg [`PPR_POS_W-1:0] ref_pos_ff;
  reg [7:0] et_hi_ff;
  reg [3:0] ihl_ff;
  reg is_v4_ff;
  reg is_v6_ff;
  wire [`PPR_POS_W-1:0] pos;
  wire [`PPR_POS_W-1:0] rel;
  wire [15:0] etype;
  wire [`PPR_POS_W-1:0] v4_end;

  assign pos = rx_sof ? {`PPR_POS_W{1'b0}} : cnt_ff;
  assign rel = pos - msg_pos_ff;
  assign etype = {et_hi_ff, rx_data};
  // ip header length in words, then the fixed udp header
  assign v4_end = et_pos_ff + `PPR_L3_OFS + {5'h00, ihl_ff, 2'b00} + `PPR_UDP_HDR;

  // ----------------------------------------------------------------
  // identity octets sit 20..29 bytes into the message
  // ----------------------------------------------------------------
  assign id_stb = rx_valid && (msg_pos_ff != `PPR_POS_NONE) && (pos >= msg_pos_ff)
                  && (rel >= `PPR_ID_FIRST) && (rel <= `PPR_ID_LAST);
  assign id_first = id_stb && (rel == `PPR_ID_FIRST);
  assign id_last = id_stb && (rel == `PPR_ID_LAST);

  // ----------------------------------------------------------------
  // header walk
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= {`PPR_POS_W{1'b0}};
      et_pos_ff <= `PPR_ETYPE_POS;
      msg_pos_ff <= `PPR_POS_NONE;
      ref_pos_ff <= {`PPR_POS_W{1'b0}};
      et_hi_ff <= 8'h00;
      ihl_ff <= 4'h0;
      is_v4_ff <= 1'b0;
      is_v6_ff <= 1'b0;
      offset_ff <= {`PPR_OFF_W{1'b0}};
    end
    else if (rx_valid)
    begin
      cnt_ff <= pos + 11'h001;
      if (rx_sof)
      begin
        et_pos_ff <= `PPR_ETYPE_POS;
        msg_pos_ff <= `PPR_POS_NONE;
        is_v4_ff <= 1'b0;
        is_v6_ff <= 1'b0;
      end
      if (pos == et_pos_ff)
        et_hi_ff <= rx_data;
      if (pos == et_pos_ff + 11'h001)
      begin
        // one vlan tag moves the type field; layer 2 wins over ip
        if (etype == `PPR_TPID && et_pos_ff == `PPR_ETYPE_POS)
          et_pos_ff <= `PPR_VLAN_ETYPE_POS;
        else if (etype == type_match)
        begin
          msg_pos_ff <= pos + 11'h001;
          ref_pos_ff <= et_pos_ff;
        end
        else if (etype == `PPR_TYPE_IPV4)
          is_v4_ff <= 1'b1;
        else if (etype == `PPR_TYPE_IPV6)
          is_v6_ff <= 1'b1;
      end
      if (is_v4_ff && pos == et_pos_ff + `PPR_L3_OFS)
        ihl_ff <= rx_data[3:0];
      if (is_v4_ff && pos == et_pos_ff + `PPR_V4_PROTO_OFS && rx_data == `PPR_PROTO_UDP)
      begin
        msg_pos_ff <= v4_end;
        ref_pos_ff <= v4_end;
      end
      if (is_v6_ff && pos == et_pos_ff + `PPR_V6_NH_OFS && rx_data == `PPR_PROTO_UDP)
      begin
        msg_pos_ff <= et_pos_ff + `PPR_V6_UDP_END;
        ref_pos_ff <= et_pos_ff + `PPR_V6_UDP_END;
      end
      if (!rx_sof && pos == msg_pos_ff)
        offset_ff <= msg_pos_ff[`PPR_OFF_W-1:0] - ref_pos_ff[`PPR_OFF_W-1:0];
    end
  end

endmodule

// ===== src/ppr_id_hash.v
/*
  identity hash: folds the ten source identity octets into 12 bits.
  assumes: stb per octet, first on the first octet, last on the tenth.
*/
`timescale 1ns/10ps
`include "ppr_consts.vh"

module ppr_id_hash #(
  parameter HASH_SEL = 0
) (
  input wire aclk,
  input wire aresetn,
  input wire stb,
  input wire first,
  input wire last,
  input wire [7:0] data,
  output reg [`PPR_HASH_W-1:0] hash_ff,
  output reg done_ff
);

  wire [`PPR_HASH_W-1:0] base;
  wire [`PPR_HASH_W-1:0] nxt_hash;

  assign base = first ? {`PPR_HASH_W{1'b0}} : hash_ff;

  // ----------------------------------------------------------------
  // swappable fold: rotate-xor or a crc-like step
  // ----------------------------------------------------------------
  generate
    if (HASH_SEL == 0)
    begin : g_rot
      assign nxt_hash = {base[10:0], base[11]} ^ {4'h0, data};
    end
    else
    begin : g_crc
      assign nxt_hash = ({base[10:0], 1'b0} ^ {4'h0, data})
                        ^ (base[11] ? 12'h80f : 12'h000);
    end
  endgenerate

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hash_ff <= {`PPR_HASH_W{1'b0}};
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= stb && last;
      if (stb)
        hash_ff <= nxt_hash;
    end
  end

endmodule

// ===== src/ppr_regs.v
/*
  ptp parser register bank on an axi4-lite slave: message offset,
  general-purpose pin monitor, source identity hash filter, layer 2 type.
  assumes: byte stream, pins and timestamp strobes synchronous to aclk;
  one write and one read under way at a time.
*/
`timescale 1ns/10ps
`include "ppr_consts.vh"

module ppr_regs #(
  parameter ADDR_W = 12,
  parameter TS_W = 64,
  parameter HASH_SEL = 0
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [`PPR_GPIO_W-1:0] gpio_in,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_sof,
  input wire rx_ts_valid,
  input wire [TS_W-1:0] rx_ts,
  input wire tx_ts_insert_in,
  output reg rx_ts_out_valid,
  output reg [TS_W-1:0] rx_ts_out,
  output reg tx_ts_insert
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [15:0] layer2_type_match_value_ff;
  reg hash_en_ff;
  reg [`PPR_HASH_W-1:0] expected_identity_hash_ff;
  reg id_match_ff;
  reg aw_hold_ff;
  reg w_hold_ff;
  reg [ADDR_W-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  wire [`PPR_OFF_W-1:0] message_offset_field;
  wire [`PPR_GPIO_W-1:0] pin_level_snapshot;
  wire id_stb;
  wire id_first;
  wire id_last;
  wire [`PPR_HASH_W-1:0] id_hash;
  wire id_done;

  // ----------------------------------------------------------------
  // parser and hash
  // ----------------------------------------------------------------
  ppr_frame_scan u_scan (
    .aclk(aclk),
    .aresetn(aresetn),
    .type_match(layer2_type_match_value_ff),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_sof(rx_sof),
    .offset_ff(message_offset_field),
    .id_stb(id_stb),
    .id_first(id_first),
    .id_last(id_last)
  );

  ppr_id_hash #(
    .HASH_SEL(HASH_SEL)
  ) u_hash (
    .aclk(aclk),
    .aresetn(aresetn),
    .stb(id_stb),
    .first(id_first),
    .last(id_last),
    .data(rx_data),
    .hash_ff(id_hash),
    .done_ff(id_done)
  );

  assign pin_level_snapshot = gpio_in;

  // ----------------------------------------------------------------
  // timestamp gate
  // ----------------------------------------------------------------
  // match is per frame; a frame without identity octets never matches
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      id_match_ff <= 1'b0;
      rx_ts_out_valid <= 1'b0;
      rx_ts_out <= {TS_W{1'b0}};
      tx_ts_insert <= 1'b0;
    end
    else
    begin
      if (rx_valid && rx_sof)
        id_match_ff <= 1'b0;
      else if (id_done)
        id_match_ff <= (id_hash == expected_identity_hash_ff);
      rx_ts_out_valid <= rx_ts_valid && (!hash_en_ff || id_match_ff);
      if (rx_ts_valid)
        rx_ts_out <= rx_ts;
      tx_ts_insert <= tx_ts_insert_in;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  wire aw_take;
  wire w_take;
  wire aw_have;
  wire w_have;
  wire do_wr;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [`PPR_IDX_W-1:0] wr_idx;
  wire wr_mapped;
  wire nxt_aw_hold;
  wire nxt_w_hold;
  wire nxt_bvalid;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign aw_have = aw_hold_ff || aw_take;
  assign w_have = w_hold_ff || w_take;
  assign do_wr = aw_have && w_have;
  assign wr_addr = aw_take ? s_axi_awaddr : awaddr_ff;
  assign wr_data = w_take ? s_axi_wdata : wdata_ff;
  assign wr_strb = w_take ? s_axi_wstrb : wstrb_ff;
  assign wr_idx = wr_addr[`PPR_IDX_W+1:2];
  assign wr_mapped = (wr_addr[ADDR_W-1:`PPR_IDX_W+2] == {(ADDR_W-`PPR_IDX_W-2){1'b0}})
                     && (wr_idx >= `PPR_IDX_ETYPE) && (wr_idx <= `PPR_IDX_HASH);
  assign nxt_aw_hold = aw_have && !do_wr;
  assign nxt_w_hold = w_have && !do_wr;
  assign nxt_bvalid = do_wr || (s_axi_bvalid && !s_axi_bready);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= {ADDR_W{1'b0}};
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPR_RESP_OKAY;
      layer2_type_match_value_ff <= `PPR_ETYPE_RST;
      hash_en_ff <= 1'b0;
      expected_identity_hash_ff <= {`PPR_HASH_W{1'b0}};
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      if (aw_take)
        awaddr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      // hold off new work until the response is gone
      s_axi_awready <= !nxt_aw_hold && !nxt_bvalid;
      s_axi_wready <= !nxt_w_hold && !nxt_bvalid;
      s_axi_bvalid <= nxt_bvalid;
      if (do_wr)
        s_axi_bresp <= wr_mapped ? `PPR_RESP_OKAY : `PPR_RESP_SLVERR;
      if (do_wr && wr_mapped && wr_idx == `PPR_IDX_ETYPE)
      begin
        if (wr_strb[0])
          layer2_type_match_value_ff[7:0] <= wr_data[7:0];
        if (wr_strb[1])
          layer2_type_match_value_ff[15:8] <= wr_data[15:8];
      end
      // bits 15:13 and 31:16 have no storage, so writes there vanish
      if (do_wr && wr_mapped && wr_idx == `PPR_IDX_HASH)
      begin
        if (wr_strb[0])
          expected_identity_hash_ff[7:0] <= wr_data[7:0];
        if (wr_strb[1])
        begin
          expected_identity_hash_ff[11:8] <= wr_data[11:8];
          hash_en_ff <= wr_data[`PPR_HASH_EN_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire ar_take;
  wire [`PPR_IDX_W-1:0] rd_idx;
  wire rd_high_zero;
  wire nxt_rvalid;
  reg [31:0] rd_mux;
  reg rd_mapped;

  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[`PPR_IDX_W+1:2];
  assign rd_high_zero = (s_axi_araddr[ADDR_W-1:`PPR_IDX_W+2]
                         == {(ADDR_W-`PPR_IDX_W-2){1'b0}});
  assign nxt_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_mapped = rd_high_zero;
    case (rd_idx)
      `PPR_IDX_ETYPE:
        rd_mux[15:0] = layer2_type_match_value_ff;
      `PPR_IDX_OFF:
        rd_mux[`PPR_OFF_W-1:0] = message_offset_field;
      `PPR_IDX_GPIO:
        rd_mux[`PPR_GPIO_W-1:0] = pin_level_snapshot;
      `PPR_IDX_HASH:
        rd_mux[`PPR_HASH_EN_BIT:0] = {hash_en_ff, expected_identity_hash_ff};
      default:
        rd_mapped = 1'b0;
    endcase
  end

  // the pin levels are caught on the edge that takes the address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PPR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !nxt_rvalid;
      s_axi_rvalid <= nxt_rvalid;
      if (ar_take)
      begin
        s_axi_rdata <= rd_mapped ? rd_mux : 32'h0000_0000;
        s_axi_rresp <= rd_mapped ? `PPR_RESP_OKAY : `PPR_RESP_SLVERR;
      end
    end
  end

endmodule

// ===== test/ppr_regs_monitor.sv
/*
  checker of the ptp parser register bank: read and write channels,
  pin monitor, rx timestamp gate, insertion pass-through.
  assumes: bound to ppr_regs, one aclk domain.
*/
`timescale 1ns/10ps

module ppr_regs_monitor #(
  parameter ADDR_W = 12,
  parameter TS_W = 64
) (
  input wire aclk,
  input wire aresetn,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [11:0] gpio_in,
  input wire rx_ts_valid,
  input wire [TS_W-1:0] rx_ts,
  input wire tx_ts_insert_in,
  input wire rx_ts_out_valid,
  input wire [TS_W-1:0] rx_ts_out,
  input wire tx_ts_insert
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire bad_a = (s_axi_araddr < 12'h070) || (s_axi_araddr > 12'h07c);

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("arready while rvalid");
  property p_r_answer;
    rd_take |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  property p_pins;
    rd_take && s_axi_araddr == 12'h078 |=> s_axi_rdata == {20'h00000, $past(gpio_in)};
  endproperty
  a_pins: assert property (p_pins) else $error("pin read wrong");
  property p_off_top;
    rd_take && s_axi_araddr == 12'h074 |=> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_off_top: assert property (p_off_top) else $error("offset top bits set");
  property p_hash_top;
    rd_take && s_axi_araddr == 12'h07c |=> s_axi_rdata[31:13] == 19'h00000;
  endproperty
  a_hash_top: assert property (p_hash_top) else $error("hash top bits set");
  property p_unmapped;
    rd_take && bad_a |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answer");
  property p_tx_pass;
    $past(aresetn) |-> tx_ts_insert == $past(tx_ts_insert_in);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("insertion gated");
  property p_ts_gate;
    rx_ts_out_valid |-> $past(rx_ts_valid) && rx_ts_out == $past(rx_ts);
  endproperty
  a_ts_gate: assert property (p_ts_gate) else $error("stray timestamp");

  c_pins: cover property (rd_take && s_axi_araddr == 12'h078);
  c_ts: cover property (rx_ts_out_valid);
  c_bad: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

// ===== test/test_ppr_regs.sv
/*
  testbench of the ptp parser register bank.
  assumes: HASH_SEL 0, 250 MHz aclk, bench drives every port itself.
*/
`timescale 1ns/10ps

module test_ppr_regs;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [11:0] gpio_in = 12'h000;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_sof = 1'b0;
  logic rx_ts_valid = 1'b0;
  logic [63:0] rx_ts = 64'h0;
  logic tx_ts_insert_in = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire rx_ts_out_valid, tx_ts_insert;
  wire [63:0] rx_ts_out;
  int mismatches = 0;
  int n_checks = 0;
  logic [1:0] resp;
  logic [31:0] rd;

  ppr_regs #(.ADDR_W(12), .TS_W(64), .HASH_SEL(0)) i_ppr_regs (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .gpio_in(gpio_in), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_sof(rx_sof), .rx_ts_valid(rx_ts_valid), .rx_ts(rx_ts),
    .tx_ts_insert_in(tx_ts_insert_in), .rx_ts_out_valid(rx_ts_out_valid),
    .rx_ts_out(rx_ts_out), .tx_ts_insert(tx_ts_insert)
  );

  always #2 aclk = ~aclk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // readies are registers, so the level at the falling edge is the one sampled next
  task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(negedge aclk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      @(posedge aclk);
      if (!aw) s_axi_awvalid <= 1'b0;
      if (!w) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [11:0] id_hash(input logic [79:0] id);
    logic [11:0] h;
    h = 12'h000;
    for (int n = 9; n >= 0; n--)
      h = {h[10:0], h[11]} ^ {4'h0, id[8*n +: 8]};
    return h;
  endfunction

  // k 0: layer 2, k 1: udp over ipv4, k 2: udp over ipv6; identity at bytes 34..43 in k 0 only
  // 64 bytes: an ipv6 message start misplaced past byte 63 leaves the offset stale
  function automatic logic [7:0] fb(input int k, input int i, input logic [79:0] id);
    fb = 8'(i);
    if (i == 12) fb = (k == 0) ? 8'hf7 : (k == 1) ? 8'h08 : 8'h86;
    if (i == 13) fb = (k == 0) ? 8'h88 : (k == 1) ? 8'h00 : 8'hdd;
    if (k == 1 && i == 14) fb = 8'h45;
    if (k == 1 && i == 23) fb = 8'h11;
    if (k == 2 && i == 20) fb = 8'h11;
    if (k == 0 && i >= 34 && i <= 43) fb = id[8*(43-i) +: 8];
  endfunction

  task frame(input int k, input logic [79:0] id);
    for (int i = 0; i < 64; i++)
    begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_data <= fb(k, i, id);
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task ts_try(input logic e);
    @(posedge aclk);
    rx_ts_valid <= 1'b1;
    rx_ts <= 64'h0123_4567_89ab_cdef;
    tx_ts_insert_in <= 1'b1;
    @(posedge aclk);
    rx_ts_valid <= 1'b0;
    tx_ts_insert_in <= 1'b0;
    @(negedge aclk);
    chk("ts valid", {31'h0, e}, {31'h0, rx_ts_out_valid});
    chk("tx insert", 32'h1, {31'h0, tx_ts_insert});
    if (e) chk("ts data lo", 32'h89ab_cdef, rx_ts_out[31:0]);
    if (e) chk("ts data hi", 32'h0123_4567, rx_ts_out[63:32]);
    @(negedge aclk);
    chk("ts pulse", 32'h0, {31'h0, rx_ts_out_valid});
    chk("tx pulse", 32'h0, {31'h0, tx_ts_insert});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rdr(12'h070, rd, resp);
    chk("type reset", 32'h0000_f788, rd);
    chk("rd resp", 32'h0, {30'h0, resp});
    rdr(12'h07c, rd, resp);
    chk("hash reset", 32'h0, rd);
    wr(12'h07c, 32'hffff_ffff, resp);
    rdr(12'h07c, rd, resp);
    chk("hash reg", 32'h0000_1fff, rd);
    // lane 0 only: enable and upper hash bits must survive
    s_axi_wstrb <= 4'h1;
    wr(12'h07c, 32'h0, resp);
    s_axi_wstrb <= 4'hf;
    rdr(12'h07c, rd, resp);
    chk("hash lane 0", 32'h0000_1f00, rd);
    wr(12'h100, 32'h1, resp);
    chk("bad wr resp", 32'h2, {30'h0, resp});
    rdr(12'h100, rd, resp);
    chk("bad rd resp", 32'h2, {30'h0, resp});
  endtask

  task t_gpio;
    logic [11:0] p;
    for (int j = 0; j < 3; j++)
    begin
      p = (j == 0) ? 12'h001 : (j == 1) ? 12'h800 : 12'ha5c;
      gpio_in <= p;
      rdr(12'h078, rd, resp);
      chk("pins", {20'h0, p}, rd);
    end
    wr(12'h078, 32'hffff_ffff, resp);
    rdr(12'h078, rd, resp);
    chk("pins ro", 32'h0000_0a5c, rd);
  endtask

  task t_frames;
    frame(0, 80'h0);
    rdr(12'h074, rd, resp);
    chk("l2 offset", 32'h2, rd);
    wr(12'h074, 32'hffff_ffff, resp);
    chk("ro wr resp", 32'h0, {30'h0, resp});
    rdr(12'h074, rd, resp);
    chk("offset ro", 32'h2, rd);
    frame(1, 80'h0);
    rdr(12'h074, rd, resp);
    chk("udp offset", 32'h0, rd);
    wr(12'h070, 32'h0000_0800, resp);
    frame(1, 80'h0);
    rdr(12'h074, rd, resp);
    chk("type offset", 32'h2, rd);
    wr(12'h070, 32'h0000_f788, resp);
    frame(2, 80'h0);
    rdr(12'h074, rd, resp);
    chk("udp6 offset", 32'h0, rd);
  endtask

  task t_filter;
    wr(12'h07c, {19'h0, 1'b1, id_hash(80'h0011_2233_4455_6677_8899)}, resp);
    frame(0, 80'h0011_2233_4455_6677_8899);
    ts_try(1'b1);
    frame(0, 80'h0011_2233_4455_6677_8898);
    ts_try(1'b0);
    wr(12'h07c, 32'h0, resp);
    ts_try(1'b1);
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_gpio();
    t_frames();
    t_filter();
    conclude();
  end

  // whole run needs about 500 cycles; this allows a hundred times that
  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule

bind ppr_regs ppr_regs_monitor #(.ADDR_W(ADDR_W), .TS_W(TS_W)) i_ppr_regs_monitor (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gpio_in(gpio_in),
  .rx_ts_valid(rx_ts_valid), .rx_ts(rx_ts), .tx_ts_insert_in(tx_ts_insert_in),
  .rx_ts_out_valid(rx_ts_out_valid), .rx_ts_out(rx_ts_out), .tx_ts_insert(tx_ts_insert)
);
